// File: design/osrp_top.sv
// Serial command receiver and programming engine for the security registers.
`timescale 1ns/100ps
module osrp_top #(
  parameter int unsigned PROGRAM_CYCLES = osrp_pkg::OTP_PROGRAM_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sck_in,
  input wire logic spi_si_in,
  input wire logic [8:0] otp_read_addr_in,
  output logic [7:0] otp_read_data_out,
  output logic [7:0] status_reg1_out,
  output logic [7:0] status_reg2_out,
  output logic write_enable_latch_out,
  output logic operation_in_progress_flag_out,
  output logic [2:0] user_otp_lock_flags_out
);
  osrp_fifo_if #(.WIDTH(8)) rx_if ();
  osrp_fifo_if #(.WIDTH(8)) buf_if ();

  osrp_pkg::osrp_state_t state;
  logic sck_prev;
  logic cs_prev;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic [2:0] phase;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic cmd_ok;
  logic overrun;
  logic pend_prog;
  logic write_enable_latch;
  logic [2:0] lock_flags;
  logic [7:0] stage_buf [osrp_pkg::BUF_BYTES];
  logic [7:0] otp_mem [osrp_pkg::OTP_BYTES];
  logic [7:0] buf_ptr;
  logic [8:0] byte_count;
  logic [8:0] prog_idx;
  logic [8:0] prog_addr;
  logic [7:0] stage_q;
  logic [7:0] otp_q;
  logic [16:0] wait_cnt;
  logic sck_rise;
  logic cs_release;
  logic byte_done;
  logic [7:0] next_byte;
  logic release_whole;
  logic start_prog;
  logic abort_prog;
  logic otp_we;

  function automatic logic [7:0] factory_byte(input int unsigned idx);
    factory_byte = 8'(idx) ^ osrp_pkg::FACTORY_FILL;
  endfunction : factory_byte

  function automatic logic reg_locked(input logic [1:0] reg_sel, input logic [2:0] flags);
    reg_locked = (reg_sel == 2'h0) || flags[reg_sel - 2'h1];
  endfunction : reg_locked

  assign sck_rise = enable_in && !spi_cs_n_in && spi_sck_in && !sck_prev;
  assign cs_release = enable_in && spi_cs_n_in && !cs_prev;
  assign byte_done = sck_rise && (bit_cnt == 3'h7);
  assign next_byte = {shift[6:0], spi_si_in};
  assign release_whole = (bit_cnt == 3'h0);
  // Whole register 0 is refused up front, so factory bytes can never be written.
  assign start_prog = enable_in && state == osrp_pkg::S_DRAIN && !buf_if.valid
    && !overrun && byte_count != 9'h0
    && !reg_locked(addr[osrp_pkg::ADDR_REG_MSB:osrp_pkg::ADDR_REG_LSB], lock_flags);
  assign abort_prog = enable_in && state == osrp_pkg::S_DRAIN && !buf_if.valid && !start_prog;
  assign otp_we = enable_in && state == osrp_pkg::S_WRITE;

  assign rx_if.valid = byte_done && cmd_ok && phase == 3'(osrp_pkg::PHASE_DATA);
  assign rx_if.data = next_byte;
  assign buf_if.ready = state == osrp_pkg::S_IDLE || state == osrp_pkg::S_DRAIN;

  osrp_fifo #(.WIDTH(8), .DEPTH(osrp_pkg::FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(enable_in),
    .fill(rx_if.sink),
    .drain(buf_if.source)
  );

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else if (enable_in) begin
      sck_prev <= spi_sck_in;
      cs_prev <= spi_cs_n_in;
    end
  end

  // Bits are taken on rising serial clock edges only, as in modes 0 and 3.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      phase <= 3'h0;
      opcode <= 8'h00;
      addr <= 24'h000000;
    end else if (enable_in && spi_cs_n_in) begin
      bit_cnt <= 3'h0;
      phase <= 3'h0;
    end else if (sck_rise) begin
      shift <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        if (phase == 3'h0) begin
          opcode <= next_byte;
        end else if (phase < 3'(osrp_pkg::PHASE_DATA)) begin
          addr <= {addr[15:0], next_byte};
        end
        if (phase < 3'(osrp_pkg::PHASE_DATA)) begin
          phase <= phase + 3'h1;
        end
      end
    end
  end

  // The command is honoured only when the latch was set and nothing is running.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cmd_ok <= 1'b0;
    end else if (enable_in && spi_cs_n_in) begin
      cmd_ok <= 1'b0;
    end else if (byte_done && phase == 3'h0) begin
      cmd_ok <= next_byte == osrp_pkg::OPC_PROGRAM && write_enable_latch
        && state == osrp_pkg::S_IDLE;
    end
  end

  // A byte the FIFO cannot take poisons the whole command instead of being lost silently.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      overrun <= 1'b0;
    end else if (byte_done && phase == 3'h0) begin
      overrun <= 1'b0;
    end else if (rx_if.valid && !rx_if.ready) begin
      overrun <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pend_prog <= 1'b0;
    end else if (enable_in) begin
      pend_prog <= cs_release && cmd_ok && release_whole
        && phase == 3'(osrp_pkg::PHASE_DATA);
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      write_enable_latch <= 1'b0;
    end else if (start_prog || abort_prog) begin
      write_enable_latch <= 1'b0;
    end else if (cs_release && cmd_ok && !(release_whole
        && phase == 3'(osrp_pkg::PHASE_DATA))) begin
      write_enable_latch <= 1'b0;
    end else if (cs_release && release_whole && phase == 3'h1
        && opcode == osrp_pkg::OPC_WRITE_ENABLE && state == osrp_pkg::S_IDLE) begin
      write_enable_latch <= 1'b1;
    end
  end

  // Each accepted command restarts the staging buffer, so old contents never leak in.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      buf_ptr <= 8'h00;
      byte_count <= 9'h000;
    end else if (byte_done && phase == 3'h0 && state == osrp_pkg::S_IDLE) begin
      // A command heard while busy must not shrink the count of bytes being programmed.
      buf_ptr <= 8'h00;
      byte_count <= 9'h000;
    end else if (enable_in && buf_if.valid && buf_if.ready) begin
      buf_ptr <= buf_ptr + 8'h01;
      if (byte_count != 9'(osrp_pkg::BUF_BYTES)) begin
        byte_count <= byte_count + 9'h001;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (enable_in && buf_if.valid && buf_if.ready) begin
      stage_buf[buf_ptr] <= buf_if.data;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= osrp_pkg::S_IDLE;
    end else if (enable_in) begin
      unique case (state)
        osrp_pkg::S_IDLE: begin
          if (pend_prog) begin
            state <= osrp_pkg::S_DRAIN;
          end
        end
        osrp_pkg::S_DRAIN: begin
          if (start_prog) begin
            state <= osrp_pkg::S_READ;
          end else if (abort_prog) begin
            state <= osrp_pkg::S_IDLE;
          end
        end
        osrp_pkg::S_READ: begin
          state <= osrp_pkg::S_WRITE;
        end
        osrp_pkg::S_WRITE: begin
          if (prog_idx + 9'h001 == byte_count) begin
            state <= osrp_pkg::S_WAIT;
          end else begin
            state <= osrp_pkg::S_READ;
          end
        end
        osrp_pkg::S_WAIT: begin
          if (wait_cnt == 17'(PROGRAM_CYCLES)) begin
            state <= osrp_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // Offsets wrap inside the selected register, so a long burst never spills over.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      prog_idx <= 9'h000;
      prog_addr <= 9'h000;
    end else if (start_prog) begin
      prog_idx <= 9'h000;
      prog_addr <= addr[8:0];
    end else if (otp_we) begin
      prog_idx <= prog_idx + 9'h001;
      prog_addr <= {prog_addr[osrp_pkg::ADDR_REG_MSB:osrp_pkg::ADDR_REG_LSB],
        prog_addr[osrp_pkg::ADDR_OFFSET_MSB:0] + 7'h01};
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      stage_q <= osrp_pkg::ERASED_BYTE;
      otp_q <= osrp_pkg::ERASED_BYTE;
    end else if (enable_in && state == osrp_pkg::S_READ) begin
      stage_q <= stage_buf[prog_idx[7:0]];
      otp_q <= otp_mem[prog_addr];
    end
  end

  // Programming only clears bits, so repeated commands clear more bits and never restore them.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      for (int i = 0; i < osrp_pkg::OTP_BYTES; i++) begin
        otp_mem[i] <= (i < osrp_pkg::REG_BYTES) ? factory_byte(i) : osrp_pkg::ERASED_BYTE;
      end
    end else if (otp_we) begin
      otp_mem[prog_addr] <= otp_q & stage_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wait_cnt <= 17'h00000;
    end else if (enable_in) begin
      if (state == osrp_pkg::S_WAIT) begin
        wait_cnt <= wait_cnt + 17'h00001;
      end else begin
        wait_cnt <= 17'h00000;
      end
    end
  end

  // A lock flag follows any cleared bit in the top byte of its register.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      lock_flags <= 3'h0;
    end else if (enable_in) begin
      for (int k = 1; k < osrp_pkg::REG_COUNT; k++) begin
        lock_flags[k-1] <= otp_mem[{2'(k), osrp_pkg::TOP_OFFSET}] != osrp_pkg::ERASED_BYTE;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      otp_read_data_out <= 8'h00;
    end else if (enable_in) begin
      otp_read_data_out <= otp_mem[otp_read_addr_in];
    end
  end

  always_comb begin
    operation_in_progress_flag_out = state != osrp_pkg::S_IDLE;
    write_enable_latch_out = write_enable_latch;
    user_otp_lock_flags_out = lock_flags;
    status_reg1_out = 8'h00;
    status_reg1_out[osrp_pkg::SR1_BUSY_BIT] = state != osrp_pkg::S_IDLE;
    status_reg1_out[osrp_pkg::SR1_LATCH_BIT] = write_enable_latch;
    status_reg2_out = 8'h00;
    status_reg2_out[osrp_pkg::SR2_LOCK_LSB +: 3] = lock_flags;
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  sequence s_good_release;
    cs_release && cmd_ok && release_whole && phase == 3'(osrp_pkg::PHASE_DATA);
  endsequence

  sequence s_drained;
    state == osrp_pkg::S_DRAIN && !buf_if.valid && enable_in;
  endsequence

  a_release_drains: assert property (s_good_release |-> ##2 state == osrp_pkg::S_DRAIN)
    else $error("Whole-byte release did not start the drain.");
  a_midbyte_aborts: assert property (cs_release && !release_whole |=> !pend_prog)
    else $error("Mid-byte release queued a program.");
  a_factory_kept: assert property (otp_we |-> prog_addr[8:7] != 2'h0)
    else $error("Factory register was written.");
  a_locked_refused: assert property (s_drained ##0 lock_flags[0] && addr[8:7] == 2'h1
    |=> state == osrp_pkg::S_IDLE)
    else $error("Locked register was not refused.");
  a_latch_before_end: assert property (start_prog |=> !write_enable_latch
    throughout (state != osrp_pkg::S_IDLE)[*2])
    else $error("Latch still set during programming.");
  a_incomplete_clears: assert property (cs_release && cmd_ok && !release_whole
    |=> !write_enable_latch)
    else $error("Latch kept after incomplete transfer.");
  a_busy_while_prog: assert property ($rose(state == osrp_pkg::S_READ)
    |-> operation_in_progress_flag_out && status_reg1_out[0])
    else $error("Busy flag low while programming.");
  a_lock_follows_top: assert property (otp_we && prog_addr[6:0] == 7'h7F
    && (otp_q & stage_q) != 8'hFF && enable_in ##1 enable_in
    |=> lock_flags[prog_addr[8:7] - 2'h1] && status_reg2_out[3 + prog_addr[8:7] - 1])
    else $error("Top byte programmed without lock.");
  a_no_latch_ignored: assert property (byte_done && phase == 3'h0 && !write_enable_latch
    |=> !cmd_ok)
    else $error("Command taken with latch clear.");
  a_opcode_order: assert property (byte_done && phase == 3'h0 |=> opcode == $past(next_byte))
    else $error("Opcode bits assembled out of order.");
endmodule : osrp_top

// File: inc/osrp_pkg.sv
// Constants and types shared by the security register program block.
package osrp_pkg;
  localparam logic [7:0] OPC_PROGRAM = 8'h9B;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam int unsigned SR1_BUSY_BIT = 0;
  localparam int unsigned SR1_LATCH_BIT = 1;
  localparam int unsigned SR2_LOCK_LSB = 3;
  localparam int unsigned ADDR_OFFSET_MSB = 6;
  localparam int unsigned ADDR_REG_LSB = 7;
  localparam int unsigned ADDR_REG_MSB = 8;
  localparam int unsigned REG_BYTES = 128;
  localparam int unsigned REG_COUNT = 4;
  localparam int unsigned OTP_BYTES = 512;
  localparam int unsigned BUF_BYTES = 256;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned PHASE_DATA = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [6:0] TOP_OFFSET = 7'h7F;
  // Arbitrary fill for the factory register, not any real serial value.
  localparam logic [7:0] FACTORY_FILL = 8'hA5;
  localparam int unsigned CLOCK_PERIOD_NS = 8;
  localparam int unsigned OTP_PROGRAM_TIME_US = 500;
  localparam int unsigned OTP_PROGRAM_CYCLES = OTP_PROGRAM_TIME_US * 1000 / CLOCK_PERIOD_NS;
  typedef enum logic [2:0] {S_IDLE, S_DRAIN, S_READ, S_WRITE, S_WAIT} osrp_state_t;
endpackage : osrp_pkg

// File: inc/osrp_fifo_if.sv
// Valid and ready byte channel between the receiver and the staging buffer.
`timescale 1ns/100ps
interface osrp_fifo_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : osrp_fifo_if

// File: design/osrp_fifo.sv
// Small synchronous FIFO that decouples serial byte capture from buffering.
`timescale 1ns/100ps
module osrp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  osrp_fifo_if.sink fill,
  osrp_fifo_if.source drain
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign fill.ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign drain.valid = wr_ptr != rd_ptr;
  assign drain.data = mem[rd_ptr[AW-1:0]];
  assign push = enable_in && fill.valid && fill.ready;
  assign pop = enable_in && drain.valid && drain.ready;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= fill.data;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : osrp_fifo

// File: tb/osrp_host_model.sv
// Host serial controller model that drives the command pins of the block.
`timescale 1ns/100ps
module osrp_host_model (
  input wire logic clock_in,
  output logic spi_cs_n_out,
  output logic spi_sck_out,
  output logic spi_si_out
);
  initial begin
    spi_cs_n_out = 1'b1;
    spi_sck_out = 1'b0;
    spi_si_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask : tick

  task automatic select();
    tick(1);
    spi_cs_n_out = 1'b0;
    tick(2);
  endtask : select

  // Every field goes out on the one data line, top bit first.
  task automatic send_bits(input logic [7:0] value, input int count);
    for (int i = 7; i > 7 - count; i--) begin
      spi_si_out = value[i];
      tick(2);
      spi_sck_out = 1'b1;
      tick(2);
      spi_sck_out = 1'b0;
    end
  endtask : send_bits

  // A released data line is not held, so it shows the inverse of its last bit.
  task automatic release_bus();
    tick(2);
    spi_cs_n_out = 1'b1;
    spi_si_out = ~spi_si_out;
    tick(6);
  endtask : release_bus
endmodule : osrp_host_model

// File: tb/testbench.sv
// Self-checking bench for the security register program block.
`timescale 1ns/100ps
module testbench;
  localparam int unsigned PROG_CYC = 20;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [8:0] rd_addr = 9'h000;
  logic cs_n;
  logic sck;
  logic si;
  logic [7:0] rd_data;
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic we_latch;
  logic busy;
  logic [2:0] locks;
  logic [7:0] exp_mem [512];
  logic [7:0] payload [$];
  logic latch_in_busy;
  int busy_len;
  int n_mismatch = 0;
  int n_tests = 0;

  always #4 clock_in = ~clock_in;

  osrp_host_model host_u (
    .clock_in(clock_in),
    .spi_cs_n_out(cs_n),
    .spi_sck_out(sck),
    .spi_si_out(si)
  );

  osrp_top #(.PROGRAM_CYCLES(PROG_CYC)) dut_u (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(1'b1),
    .spi_cs_n_in(cs_n),
    .spi_sck_in(sck),
    .spi_si_in(si),
    .otp_read_addr_in(rd_addr),
    .otp_read_data_out(rd_data),
    .status_reg1_out(sr1),
    .status_reg2_out(sr2),
    .write_enable_latch_out(we_latch),
    .operation_in_progress_flag_out(busy),
    .user_otp_lock_flags_out(locks)
  );

  task automatic give_verdict();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  // The read port is registered, so data is taken two full clocks later.
  task automatic check_mem();
    for (int a = 0; a < 512; a++) begin
      @(negedge clock_in);
      rd_addr = 9'(a);
      repeat (2) @(negedge clock_in);
      chk_byte(rd_data, exp_mem[a]);
    end
  endtask : check_mem

  // Polls the busy flag instead of sitting out the whole program time.
  task automatic finish_op();
    busy_len = 0;
    latch_in_busy = 1'b0;
    for (int i = 0; i < 4000; i++) begin
      @(negedge clock_in);
      if (busy === 1'b1) begin
        busy_len++;
        latch_in_busy = we_latch;
      end else if (busy_len > 0 || i > 60) begin
        break;
      end
    end
    chk_flag(busy, 1'b0);
  endtask : finish_op

  task automatic write_enable();
    host_u.select();
    host_u.send_bits(osrp_pkg::OPC_WRITE_ENABLE, 8);
    host_u.release_bus();
  endtask : write_enable

  task automatic prog_otp(input logic [23:0] addr, input int bits_left);
    host_u.select();
    host_u.send_bits(osrp_pkg::OPC_PROGRAM, 8);
    for (int i = 2; i >= 0; i--) begin
      host_u.send_bits(addr[8*i +: 8], 8);
    end
    foreach (payload[i]) begin
      host_u.send_bits(payload[i], 8);
    end
    if (bits_left > 0) begin
      host_u.send_bits(8'h00, bits_left);
    end
    host_u.release_bus();
    finish_op();
  endtask : prog_otp

  // Offsets wrap inside one register and programming can only clear bits.
  task automatic expect_prog(input logic [8:0] addr);
    logic [8:0] idx;
    foreach (payload[i]) begin
      idx = {addr[8:7], addr[6:0] + 7'(i)};
      exp_mem[idx] = exp_mem[idx] & payload[i];
    end
  endtask : expect_prog

  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    for (int a = 0; a < 512; a++) begin
      exp_mem[a] = (a < 128) ? (8'(a) ^ osrp_pkg::FACTORY_FILL) : osrp_pkg::ERASED_BYTE;
    end
    repeat (12) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clock_in);
    chk_byte(sr1, 8'h00);
    chk_byte(sr2, 8'h00);
    payload = '{8'h00};
    prog_otp(24'h000080, 0);
    chk_flag(busy_len > PROG_CYC, 1'b0);
    write_enable();
    chk_byte(sr1, 8'h02);
    payload = '{8'h12, 8'h34, 8'h56};
    prog_otp(24'hABC081, 0);
    expect_prog(9'h081);
    chk_flag(busy_len > PROG_CYC, 1'b1);
    chk_flag(latch_in_busy, 1'b0);
    chk_byte(sr1, 8'h00);
    write_enable();
    payload = '{8'hF0};
    prog_otp(24'h000081, 0);
    expect_prog(9'h081);
    write_enable();
    payload = '{8'h00};
    prog_otp(24'h000005, 0);
    chk_flag(we_latch, 1'b0);
    write_enable();
    prog_otp(24'h000100, 3);
    chk_flag(we_latch, 1'b0);
    write_enable();
    host_u.select();
    host_u.send_bits(osrp_pkg::OPC_PROGRAM, 8);
    host_u.send_bits(8'h00, 8);
    host_u.release_bus();
    finish_op();
    chk_flag(we_latch, 1'b0);
    check_mem();
    // An address with no data behind it has nothing to program and must not run.
    payload.delete();
    write_enable();
    prog_otp(24'h000090, 0);
    chk_flag(we_latch, 1'b0);
    chk_flag(busy_len > PROG_CYC, 1'b0);
    // A long burst streams through the byte FIFO, crosses the top byte and wraps to offset 0.
    for (int i = 0; i < 20; i++) begin
      payload.push_back(8'(i * 13));
    end
    write_enable();
    prog_otp(24'h000170, 0);
    expect_prog(9'h170);
    chk_byte(sr2, 8'h10);
    for (int r = 1; r < 4; r += 2) begin
      write_enable();
      payload = '{8'h7E};
      prog_otp(24'({r[1:0], 7'h7F}), 0);
      expect_prog({r[1:0], 7'h7F});
    end
    chk_byte(sr2, 8'h38);
    chk_byte({5'h00, locks}, 8'h07);
    for (int r = 1; r < 4; r++) begin
      write_enable();
      payload = '{8'h00};
      prog_otp(24'({r[1:0], 7'h00}), 0);
      chk_flag(we_latch, 1'b0);
      chk_flag(busy_len > PROG_CYC, 1'b0);
    end
    check_mem();
    give_verdict();
  end
endmodule : testbench
